// ===== verilog/overlap_pkg.sv
/*
  Shared constants and carriers for the instruction overlap and addressing block.
  Assumes a 36-bit word machine with 15-bit addresses and a split two-half core storage.
*/
`default_nettype none
package overlap_pkg;
  localparam int WORD_W = 36;
  localparam int ADDR_W = 15;
  // Direct address field, word bits 21..35 counted from the sign (bit 0 = msb)
  localparam int ADDR_LSB = 0;
  localparam int ADDR_MSB = 14;
  // Tag field, word bits 18..20
  localparam int TAG_LSB = 15;
  localparam int TAG_MSB = 17;
  // Indirect flag, bits 12..13 both set in the decrement area
  localparam int IND_LSB = 22;
  localparam int IND_MSB = 23;
  localparam logic [1:0] IND_CODE = 2'h3;
  // Operation code, sign and bits 1..11
  localparam int OP_LSB = 24;
  localparam int OP_MSB = 35;
  localparam logic [11:0] SHIFT_GROUP_OP = 12'h076;
  localparam logic [14:0] RESET_PC = 15'h0000;
  localparam logic [35:0] RESET_WORD = 36'h000000000;
  localparam int HALF_SEL_BIT = 0;

  typedef struct packed {
    logic [11:0] op;
    logic [1:0] ind;
    logic [3:0] spare;
    logic [2:0] tag;
    logic [14:0] addr;
  } instr_t;

  typedef struct packed {
    logic req;
    logic [14:0] addr;
  } mem_req_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH_PAIR,
    ST_INDIRECT,
    ST_EXECUTE,
    ST_ADVANCE
  } state_t;
endpackage
`default_nettype wire

// ===== verilog/instruction_overlap_addressing.sv
/*
  Instruction fetch, effective address formation and overlap control.
  Assumes two storage halves that each answer a read on the cycle after the request,
  and an execution unit that reports completion and classifies the current instruction.
*/
// Overview of operation
// RQ1 - The direct address is bits 21 to 35 of the instruction word.
// RQ2 - The tag field selects the index register that modifies the address.
// RQ3 - A tagged address is formed by subtracting the index register from the direct address.
// RQ4 - An indirect instruction reads the word at its effective address and uses that word's address.
// RQ5 - A tag on the indirect word subtracts its index register from the indirect address.
// RQ6 - Indexing may occur at both stages in one reference, each applied in order.
// RQ7 - Storage is two independent equal halves, so accesses to different halves run together.
// RQ8 - The next sequential instruction is fetched while the current one executes.
// RQ9 - In double overlap the first word goes to the program register, the next one to the backup.
// RQ10 - The backup instruction is analysed and address-modified during current execution.
// RQ11 - On completion the backup instruction moves to the program and storage registers.
// RQ12 - Double overlap starts at program start and after any broken extended sequence.
// RQ13 - The first instruction of a pair may come from any address, even or odd.
// RQ14 - Extended overlap fetches the following word into backup while passing the held one on.
// RQ15 - All instruction-phase work of the overlapping instruction runs in the backup phase; only its indexing does here, not its indirect fetch.
// RQ16 - Overlap breaks on a trap, double precision, one-cycle, or non-shift shift-group instruction.
// RQ17 - A zero tag leaves the address unmodified at both stages.
`timescale 1ns/1ps
`default_nettype none
module instruction_overlap_addressing #(
  parameter int NUM_XR = 7
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control from the processor
  input wire logic start,
  input wire logic exec_done,
  input wire logic trap,
  input wire logic cur_double_prec,
  input wire logic cur_one_cycle,
  input wire logic cur_is_shift,
  // Index register contents, entry 0 is index_register_one
  input wire logic [NUM_XR*15-1:0] index_regs,
  // Storage halves, even half 0 and odd half 1
  output var overlap_pkg::mem_req_t mem_req_even,
  output var overlap_pkg::mem_req_t mem_req_odd,
  input wire logic [35:0] rdata_even,
  input wire logic [35:0] rdata_odd,
  // Results toward execution
  output logic [35:0] program_register,
  output logic [35:0] storage_register,
  output logic [14:0] operand_addr,
  output logic operand_valid,
  output logic overlap_active
);

  ////////////////////////////////////////////////////////////////////////
  // Index selection

  logic [14:0] xr_table [0:7];
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_xr
      if (g == 0 || g > NUM_XR)
      begin : g_zero
        assign xr_table[g] = 15'h0000; // [RQ17]
      end
      else
      begin : g_reg
        assign xr_table[g] = index_regs[(g-1)*15 +: 15]; // [RQ2]
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // State

  overlap_pkg::state_t state;
  logic [14:0] pc;
  logic [35:0] backup_word;
  logic [14:0] backup_ea;
  logic backup_valid;
  logic extended;
  logic [14:0] ind_addr;

  // Decoding of the current and backup words
  overlap_pkg::instr_t cur_i;
  overlap_pkg::instr_t bak_i;
  assign cur_i = program_register;
  assign bak_i = backup_word;

  wire [14:0] cur_direct = cur_i.addr; // [RQ1]
  wire [14:0] cur_ea = cur_direct - xr_table[cur_i.tag]; // [RQ3]
  wire cur_indirect = cur_i.ind == overlap_pkg::IND_CODE;
  // Backup analysis runs during current execution
  wire [14:0] bak_ea = bak_i.addr - xr_table[bak_i.tag]; // [RQ10] [RQ15]

  // Indirect word from whichever half holds it
  wire ind_half = ind_addr[overlap_pkg::HALF_SEL_BIT];
  wire [35:0] ind_word = ind_half ? rdata_odd : rdata_even;
  overlap_pkg::instr_t ind_i;
  assign ind_i = ind_word;
  wire [14:0] final_ea = ind_i.addr - xr_table[ind_i.tag]; // [RQ4] [RQ5] [RQ6]

  // Break conditions
  wire bak_shift_group = bak_i.op == overlap_pkg::SHIFT_GROUP_OP;
  wire break_overlap = trap || cur_double_prec || cur_one_cycle
    || (bak_shift_group && !cur_is_shift); // [RQ16]

  // Fetch addresses: a pair always spans both halves whatever the parity
  wire [14:0] pc_next = pc + 15'h0001;
  wire [14:0] pc_next2 = pc + 15'h0002;
  wire pc_half = pc[overlap_pkg::HALF_SEL_BIT];
  wire [35:0] first_word = pc_half ? rdata_odd : rdata_even; // [RQ13]
  wire [35:0] second_word = pc_half ? rdata_even : rdata_odd; // [RQ7] [RQ9]
  // Taken in the cycle after the transfer, when pc has already moved on by one
  wire [35:0] third_word = pc_next[overlap_pkg::HALF_SEL_BIT] ? rdata_odd : rdata_even;

  wire fetch_pair = (state == overlap_pkg::ST_IDLE && start)
    || (state == overlap_pkg::ST_ADVANCE && !extended);
  wire fetch_ahead = state == overlap_pkg::ST_EXECUTE && operand_valid && exec_done && !break_overlap;

  overlap_pkg::mem_req_t next_req_even;
  overlap_pkg::mem_req_t next_req_odd;
  always_comb
  begin
    next_req_even = '0;
    next_req_odd = '0;
    if (fetch_pair)
    begin
      next_req_even.req = 1'b1;
      next_req_odd.req = 1'b1;
      next_req_even.addr = pc_half ? pc_next : pc;
      next_req_odd.addr = pc_half ? pc : pc_next;
    end
    else if (state == overlap_pkg::ST_EXECUTE && cur_indirect && !operand_valid)
    begin
      next_req_even.req = !cur_ea[overlap_pkg::HALF_SEL_BIT];
      next_req_odd.req = cur_ea[overlap_pkg::HALF_SEL_BIT];
      next_req_even.addr = cur_ea;
      next_req_odd.addr = cur_ea;
    end
    else if (fetch_ahead)
    begin
      // Third instruction fetched while the held one moves on
      next_req_even.req = !pc_next2[overlap_pkg::HALF_SEL_BIT]; // [RQ14]
      next_req_odd.req = pc_next2[overlap_pkg::HALF_SEL_BIT];
      next_req_even.addr = pc_next2;
      next_req_odd.addr = pc_next2;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  logic ind_pending;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= overlap_pkg::ST_IDLE;
      pc <= overlap_pkg::RESET_PC;
      program_register <= overlap_pkg::RESET_WORD;
      storage_register <= overlap_pkg::RESET_WORD;
      backup_word <= overlap_pkg::RESET_WORD;
      backup_ea <= overlap_pkg::RESET_PC;
      backup_valid <= 1'b0;
      extended <= 1'b0;
      ind_addr <= overlap_pkg::RESET_PC;
      ind_pending <= 1'b0;
      operand_addr <= overlap_pkg::RESET_PC;
      operand_valid <= 1'b0;
      overlap_active <= 1'b0;
      mem_req_even <= '0;
      mem_req_odd <= '0;
    end
    else
    begin
      mem_req_even <= next_req_even;
      mem_req_odd <= next_req_odd;
      unique case (state)
        overlap_pkg::ST_IDLE:
        begin
          if (start)
          begin
            state <= overlap_pkg::ST_FETCH_PAIR; // [RQ12]
          end
        end
        overlap_pkg::ST_FETCH_PAIR:
        begin
          program_register <= first_word; // [RQ9]
          storage_register <= first_word;
          backup_word <= second_word; // [RQ8]
          backup_valid <= 1'b1;
          overlap_active <= 1'b1;
          operand_valid <= 1'b0;
          state <= overlap_pkg::ST_EXECUTE;
        end
        overlap_pkg::ST_EXECUTE:
        begin
          backup_ea <= bak_ea; // [RQ10]
          if (!operand_valid && !ind_pending)
          begin
            if (cur_indirect)
            begin
              ind_addr <= cur_ea; // [RQ4]
              ind_pending <= 1'b1;
              state <= overlap_pkg::ST_INDIRECT;
            end
            else
            begin
              operand_addr <= cur_ea; // [RQ3] [RQ17]
              operand_valid <= 1'b1;
            end
          end
          else if (exec_done)
          begin
            operand_valid <= 1'b0;
            pc <= pc_next;
            if (break_overlap)
            begin
              extended <= 1'b0;
              backup_valid <= 1'b0;
              overlap_active <= 1'b0;
            end
            else
            begin
              program_register <= backup_word; // [RQ11]
              storage_register <= backup_word;
              extended <= 1'b1;
            end
            state <= overlap_pkg::ST_ADVANCE;
          end
        end
        overlap_pkg::ST_INDIRECT:
        begin
          // Storage answer is one cycle after the request
          operand_addr <= final_ea; // [RQ5] [RQ6]
          operand_valid <= 1'b1;
          ind_pending <= 1'b0;
          state <= overlap_pkg::ST_EXECUTE;
        end
        overlap_pkg::ST_ADVANCE:
        begin
          if (extended)
          begin
            backup_word <= third_word; // [RQ14]
            backup_valid <= 1'b1;
            state <= overlap_pkg::ST_EXECUTE;
          end
          else
          begin
            // Broken sequence restarts with a fresh pair
            state <= overlap_pkg::ST_FETCH_PAIR; // [RQ12]
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_done_ok;
    state == overlap_pkg::ST_EXECUTE && operand_valid && exec_done && !break_overlap;
  endsequence

  a_backup_transfer: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ11]
    s_done_ok |=> program_register == $past(backup_word) && storage_register == $past(backup_word))
    else $error("backup word not transferred on completion");

  a_break_clears: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ16]
    state == overlap_pkg::ST_EXECUTE && operand_valid && exec_done && break_overlap |=> !overlap_active
    ##1 state == overlap_pkg::ST_FETCH_PAIR)
    else $error("overlap not broken");

  a_direct_ea: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ3]
    state == overlap_pkg::ST_EXECUTE && !operand_valid && !ind_pending && !cur_indirect
    |=> operand_valid && operand_addr == $past(cur_direct) - $past(xr_table[cur_i.tag]))
    else $error("effective address wrong");

  a_indirect_ea: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ5]
    state == overlap_pkg::ST_INDIRECT |=> operand_valid && operand_addr == $past(final_ea))
    else $error("indirect address wrong");

  a_ind_request: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ4]
    state == overlap_pkg::ST_EXECUTE && !operand_valid && !ind_pending && cur_indirect
    |=> (mem_req_even.req || mem_req_odd.req) ##1 operand_valid)
    else $error("indirect fetch missing");

  a_pair_halves: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ7]
    state == overlap_pkg::ST_IDLE && start |=> mem_req_even.req && mem_req_odd.req
    && mem_req_even.addr[0] == 1'b0 && mem_req_odd.addr[0] == 1'b1)
    else $error("pair not spread over both halves");

  a_start_pair: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ12]
    state == overlap_pkg::ST_IDLE && start |=> ##1 overlap_active && backup_valid)
    else $error("double overlap not entered");

  a_zero_tag: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ17]
    cur_i.tag == 3'h0 |-> cur_ea == cur_direct)
    else $error("zero tag modified address");

  a_extended_fetch: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ14]
    s_done_ok |=> (mem_req_even.req || mem_req_odd.req) ##1 backup_valid)
    else $error("extended fetch missing");

  a_backup_analysis: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ10]
    s_done_ok |=> ##1 cur_ea == backup_ea)
    else $error("backup address not prepared");

endmodule
`default_nettype wire

// ===== bench/split_storage_model.sv
/*
  Behavioural model of the split two-half core storage.
  Assumes one read a half per cycle, answered while the registered request stands on the port.
*/
`timescale 1ns/1ps
`default_nettype none
module split_storage_model (
  // Clock
  input wire logic ref_clk,
  // Requests and answers
  input wire overlap_pkg::mem_req_t req_even,
  input wire overlap_pkg::mem_req_t req_odd,
  output logic [35:0] rdata_even,
  output logic [35:0] rdata_odd
);
  logic [35:0] mem [0:32767];
  logic [35:0] last_even = 36'h0;
  logic [35:0] last_odd = 36'h0;
  int half_err = 0;

  ////////////////////////////////////////////////////////////////
  // The block samples the answer at the edge after it registers the request
  // Idle halves show the inverse of their last word, so stale data never looks valid
  assign rdata_even = req_even.req ? mem[req_even.addr] : ~last_even;
  assign rdata_odd = req_odd.req ? mem[req_odd.addr] : ~last_odd;

  always @(posedge ref_clk)
  begin
    if (req_even.req)
      last_even <= mem[req_even.addr];
    if (req_odd.req)
      last_odd <= mem[req_odd.addr];
    if ((req_even.req && req_even.addr[0] !== 1'h0) || (req_odd.req && req_odd.addr[0] !== 1'h1))
      half_err <= half_err + 1;
  end
endmodule
`default_nettype wire

// ===== bench/instruction_overlap_addressing_tb.sv
/*
  Self-checking bench for the overlap and addressing block.
  Assumes the storage model answers one cycle after each request.
*/
`timescale 1ns/1ps
`default_nettype none
module instruction_overlap_addressing_tb;
  localparam logic [11:0] op_load = 12'h500;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic start = 1'h0;
  logic exec_done = 1'h0;
  logic trap = 1'h0;
  logic cur_double_prec = 1'h0;
  logic cur_one_cycle = 1'h0;
  logic cur_is_shift = 1'h0;
  logic [104:0] index_regs = 105'h0;
  overlap_pkg::mem_req_t mem_req_even;
  overlap_pkg::mem_req_t mem_req_odd;
  logic [35:0] rdata_even;
  logic [35:0] rdata_odd;
  logic [35:0] program_register;
  logic [35:0] storage_register;
  logic [14:0] operand_addr;
  logic operand_valid;
  logic overlap_active;
  logic [31:0] seed = 32'ha5ee;
  logic [14:0] pc;
  logic broke;
  logic [14:0] hand_exp [4] = '{15'h0102, 15'h0202, 15'h0302, 15'h7fff};
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;

  instruction_overlap_addressing dut (.ref_clk(ref_clk), .rst_n(rst_n), .start(start), .exec_done(exec_done),
    .trap(trap), .cur_double_prec(cur_double_prec), .cur_one_cycle(cur_one_cycle), .cur_is_shift(cur_is_shift),
    .index_regs(index_regs), .mem_req_even(mem_req_even), .mem_req_odd(mem_req_odd), .rdata_even(rdata_even),
    .rdata_odd(rdata_odd), .program_register(program_register), .storage_register(storage_register),
    .operand_addr(operand_addr), .operand_valid(operand_valid), .overlap_active(overlap_active));

  split_storage_model stor (.ref_clk(ref_clk), .req_even(mem_req_even), .req_odd(mem_req_odd),
    .rdata_even(rdata_even), .rdata_odd(rdata_odd));

  always #25 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [35:0] mk(input logic ind, input logic [2:0] tag, input logic [14:0] addr);
    return {op_load, ind ? 2'h3 : 2'h0, 4'h0, tag, addr};
  endfunction

  // Index entry k-1 is subtracted for tag k; tag 0 leaves the address alone
  function automatic logic [14:0] xr_mod(input logic [35:0] w);
    if (w[17:15] == 3'h0)
      return w[14:0];
    return w[14:0] - index_regs[(int'(w[17:15]) - 1) * 15 +: 15];
  endfunction

  function automatic logic [14:0] expect_operand(input logic [35:0] w);
    logic [14:0] a;
    a = xr_mod(w);
    if (w[23:22] == 2'h3)
      a = xr_mod(stor.mem[a]);
    return a;
  endfunction

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // One instruction: wait for its operand, compare, then finish it with a class
  task automatic run_instr(input int k);
    int n;
    logic [2:0] cls;
    n = 0;
    while (operand_valid !== 1'h1 && n < 30)
    begin
      @(negedge ref_clk);
      n++;
    end
    check(36'(operand_valid), 36'h1);
    check(program_register, stor.mem[pc]);
    check(storage_register, stor.mem[pc]);
    check(36'(operand_addr), 36'(expect_operand(stor.mem[pc])));
    if (k < 4)
      check(36'(operand_addr), 36'(hand_exp[k]));
    check(36'(overlap_active), 36'h1);
    cls = (k % 7 == 3) ? 3'h1 << ((k / 7) % 3) : 3'h0;
    {trap, cur_double_prec, cur_one_cycle} = cls;
    cur_is_shift = (k % 5 == 1);
    broke = (cls != 3'h0) || (stor.mem[pc + 15'h1][35:24] == overlap_pkg::SHIFT_GROUP_OP && !cur_is_shift);
    exec_done = 1'h1;
    @(negedge ref_clk);
    exec_done = 1'h0;
    {trap, cur_double_prec, cur_one_cycle, cur_is_shift} = 4'h0;
    @(negedge ref_clk);
    if (broke)
      check(36'(overlap_active), 36'h0);
    else
      check(36'(overlap_active), 36'h1);
    n = 0;
    while (operand_valid === 1'h1 && n < 4)
    begin
      @(negedge ref_clk);
      n++;
    end
    pc = pc + 15'h1;
  endtask

  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      stop_test();
    end
  end

  initial
  begin
    // Sign bit forced high keeps random words out of the shift-class group
    for (int a = 0; a < 32768; a++)
    begin
      seed = lfsr(seed);
      stor.mem[a] = {1'h1, seed[2:0], seed};
    end
    seed = lfsr(seed);
    index_regs = {seed[8:0], seed, ~seed, seed};
    index_regs[29:0] = {15'h0003, 15'h0002};
    stor.mem[0] = mk(1'h1, 3'h1, 15'h0106);
    stor.mem[15'h104] = mk(1'h0, 3'h0, 15'h0102);
    stor.mem[1] = mk(1'h1, 3'h0, 15'h0210);
    stor.mem[15'h210] = mk(1'h0, 3'h2, 15'h0205);
    stor.mem[2] = mk(1'h1, 3'h1, 15'h0310);
    stor.mem[15'h30e] = mk(1'h0, 3'h2, 15'h0305);
    stor.mem[3] = mk(1'h0, 3'h1, 15'h0001);
    // Shift-group words as backup: one breaks the run, the other is excused by a shift
    stor.mem[10][35:24] = overlap_pkg::SHIFT_GROUP_OP;
    stor.mem[12][35:24] = overlap_pkg::SHIFT_GROUP_OP;
    repeat (5) @(negedge ref_clk);
    rst_n = 1'h1;
    @(negedge ref_clk);
    start = 1'h1;
    @(negedge ref_clk);
    start = 1'h0;
    pc = 15'h0;
    broke = 1'h1;
    for (int k = 0; k < 44; k++)
    begin
      run_instr(k);
      if (k == 3)
        $display("test corner addressing done");
    end
    $display("test random overlap stream done");
    check(36'(stor.half_err), 36'h0);
    stop_test();
  end
endmodule
`default_nettype wire
